// ==== hw/aphi_host.sv ====
// module: host-side controller that starts, waits for and reads the converter
`timescale 1ns/1ps
module aphi_host
#(
   parameter int TIMER_PERIOD = aphi_pkg::TIMER_PERIOD_DEFAULT,
   parameter int CONV_WAIT = aphi_pkg::CONV_CYCLES
)
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // user side
   input wire logic start_req_in,
   input wire logic timer_enable_in,
   input wire logic use_delay_in,
   input wire logic byte_mode_in,
   output logic busy_out,
   output logic result_valid_out,
   output logic [aphi_pkg::RESULT_WIDTH-1:0] result_out,
   output logic irq_n_out,
   output logic host_transfer_acknowledge_n_out,
   // converter pins
   output logic conversion_start_n_out,
   output logic chip_select_n_out,
   output logic read_n_out,
   input wire logic converter_busy_n_in,
   input wire logic [aphi_pkg::RESULT_WIDTH-1:0] data_in
);
   import aphi_pkg::*;

   aphi_state_t state_reg;
   aphi_state_t state_next;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic [15:0] timer_reg;
   logic [15:0] timer_next;
   logic [RESULT_WIDTH-1:0] result_reg;
   logic [RESULT_WIDTH-1:0] result_next;
   logic valid_reg;
   logic valid_next;
   logic start_n_reg;
   logic start_n_next;
   logic cs_n_reg;
   logic cs_n_next;
   logic rd_n_reg;
   logic rd_n_next;
   logic host_transfer_acknowledge_n_n_reg;
   logic host_transfer_acknowledge_n_n_next;
   logic busy_prev_reg;
   logic busy_prev_next;
   logic busy_level;
   logic busy_rise;
   logic timer_tick;
   logic [RESULT_WIDTH-1:0] data_level;

   // one-shot request and status towards the interrupt pulse timer
   aphi_pulse_if irq_pulse();

   // ==========================================================
   // pin synchronisers
   // busy rests high, so its synchroniser resets high as well
   aphi_sync3 #(.RESET_VALUE(1'b1)) busy_sync
   (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .pin_in(converter_busy_n_in),
      .level_out(busy_level)
   );

   // data is stable while strobe is held, so sync lag is covered by the strobe length
   genvar gi;
   generate
      for (gi = 0; gi < RESULT_WIDTH; gi++)
      begin : g_data_sync
         aphi_sync3 #(.RESET_VALUE(1'b0)) data_sync
         (
            .clk_sys_in(clk_sys_in),
            .reset_in(reset_in),
            .pin_in(data_in[gi]),
            .level_out(data_level[gi])
         );
      end
   endgenerate

   // ==========================================================
   // end-of-conversion edge and one-shot interrupt
   assign busy_rise = busy_level & ~busy_prev_reg;
   assign irq_pulse.fire = busy_rise & (state_reg == APHI_CONVERT);
   assign irq_pulse.length = 16'(IRQ_PULSE_CYCLES);

   // fixed pulse length; a restart while active only stretches it
   aphi_pulse_gen irq_gen
   (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .pulse(irq_pulse)
   );

   // ==========================================================
   // free-running sample timer, independent of user requests
   assign timer_tick = timer_enable_in && (timer_reg == 16'(TIMER_PERIOD - 1));

   // count only while enabled, so a fresh enable waits a full period
   always_comb
   begin
      timer_next = timer_reg + 16'h0001;
      busy_prev_next = busy_level;
      if (!timer_enable_in || timer_tick)
      begin
         timer_next = 16'h0000;
      end
   end

   // timer and busy history run in every state, apart from the sequencer
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         timer_reg <= 16'h0000;
         // released busy pin is high, so no false edge right after reset
         busy_prev_reg <= 1'b1;
      end
      else
      begin
         timer_reg <= timer_next;
         busy_prev_reg <= busy_prev_next;
      end
   end

   // ==========================================================
   // sequencer: start, wait on busy or delay, then one or two reads
   always_comb
   begin
      state_next = state_reg;
      count_next = count_reg;
      result_next = result_reg;
      valid_next = 1'b0;
      start_n_next = 1'b1;
      cs_n_next = 1'b1;
      rd_n_next = 1'b1;
      host_transfer_acknowledge_n_n_next = 1'b1;
      unique case (state_reg)
         APHI_IDLE:
         begin
            // start decode is a separate line from the read select
            // a tick and a user request in one cycle make one conversion
            if (start_req_in || timer_tick)
            begin
               state_next = APHI_START;
               start_n_next = 1'b0;
               count_next = 16'(START_PULSE_CYCLES - 1);
            end
         end
         APHI_START:
         begin
            start_n_next = 1'b0;
            if (count_reg == 16'h0000)
            begin
               // release raises start: converter begins holding here
               start_n_next = 1'b1;
               state_next = APHI_CONVERT;
               count_next = 16'(CONV_WAIT);
            end
            else
            begin
               count_next = count_reg - 16'h0001;
            end
         end
         APHI_CONVERT:
         begin
            // no read until busy returns high or the delay has run out
            // limitation: with use_delay_in low, a converter that never releases busy parks us here
            if (count_reg != 16'h0000)
            begin
               count_next = count_reg - 16'h0001;
            end
            if ((!use_delay_in && busy_rise) ||
                (use_delay_in && count_reg == 16'h0000))
            begin
               state_next = APHI_READ_LOW;
               cs_n_next = 1'b0;
               rd_n_next = 1'b0;
               count_next = 16'(READ_STROBE_CYCLES + WAIT_STATE_CYCLES - 1);
            end
         end
         APHI_READ_LOW:
         begin
            cs_n_next = 1'b0;
            rd_n_next = 1'b0;
            // acknowledge trails select by one cycle, as a decode would
            host_transfer_acknowledge_n_n_next = 1'b0;
            if (count_reg == 16'h0000)
            begin
               // data bus driven only while select and strobe are low
               cs_n_next = 1'b1;
               rd_n_next = 1'b1;
               host_transfer_acknowledge_n_n_next = 1'b1;
               if (byte_mode_in)
               begin
                  // this strobe also loads the external nibble latch
                  result_next[LOW_BYTE_WIDTH-1:0] = data_level[LOW_BYTE_WIDTH-1:0];
                  state_next = APHI_GAP;
               end
               else
               begin
                  result_next = data_level;
                  state_next = APHI_DONE;
               end
            end
            else
            begin
               count_next = count_reg - 16'h0001;
            end
         end
         APHI_GAP:
         begin
            // second cycle goes to the latch address, converter stays deselected
            // one idle cycle lets the latch output settle before the strobe
            state_next = APHI_READ_HIGH;
            rd_n_next = 1'b0;
            count_next = 16'(READ_STROBE_CYCLES + WAIT_STATE_CYCLES - 1);
         end
         APHI_READ_HIGH:
         begin
            rd_n_next = 1'b0;
            if (count_reg == 16'h0000)
            begin
               rd_n_next = 1'b1;
               // upper bits come back from the external latch, not the converter
               result_next[RESULT_WIDTH-1:HIGH_NIBBLE_LSB] =
                  data_level[RESULT_WIDTH-1:HIGH_NIBBLE_LSB];
               state_next = APHI_DONE;
            end
            else
            begin
               count_next = count_reg - 16'h0001;
            end
         end
         APHI_DONE:
         begin
            // valid follows the last strobe by one cycle
            valid_next = 1'b1;
            state_next = APHI_IDLE;
         end
      endcase
   end

   // ==========================================================
   // sequencer registers
   // strobes come from flops so the converter pins never glitch
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         state_reg <= APHI_IDLE;
         count_reg <= 16'h0000;
         result_reg <= 12'h000;
         valid_reg <= 1'b0;
         start_n_reg <= 1'b1;
         cs_n_reg <= 1'b1;
         rd_n_reg <= 1'b1;
         host_transfer_acknowledge_n_n_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         count_reg <= count_next;
         result_reg <= result_next;
         valid_reg <= valid_next;
         start_n_reg <= start_n_next;
         cs_n_reg <= cs_n_next;
         rd_n_reg <= rd_n_next;
         host_transfer_acknowledge_n_n_reg <= host_transfer_acknowledge_n_n_next;
      end
   end

   // ==========================================================
   // outputs
   // busy spans start to valid; requests seen while it is high are dropped
   assign busy_out = (state_reg != APHI_IDLE);
   assign result_valid_out = valid_reg;
   assign result_out = result_reg;
   assign irq_n_out = ~irq_pulse.active;
   assign host_transfer_acknowledge_n_out = host_transfer_acknowledge_n_n_reg;
   assign conversion_start_n_out = start_n_reg;
   assign chip_select_n_out = cs_n_reg;
   assign read_n_out = rd_n_reg;
endmodule : aphi_host

// ==== hw/aphi_pkg.sv ====
// package: constants shared by the converter host controller
package aphi_pkg;
   // ==========================================================
   // result layout
   localparam int RESULT_WIDTH = 12;
   localparam int LOW_BYTE_WIDTH = 8;
   localparam int HIGH_NIBBLE_WIDTH = 4;
   localparam int HIGH_NIBBLE_LSB = 8;
   // ==========================================================
   // timing at 100 MHz
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_TIME_NS = 15000;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_PULSE_NS = 50;
   localparam int START_PULSE_CYCLES = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_STROBE_NS = 60;
   localparam int READ_STROBE_CYCLES = (READ_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_STATE_CYCLES = 1;
   localparam int IRQ_PULSE_CYCLES = 4;
   localparam int TIMER_PERIOD_DEFAULT = 2000;
   localparam logic [15:0] START_COUNT_MAX = 16'hFFFF;
   // ==========================================================
   // sequencer states, one-hot
   typedef enum logic [6:0] {
      APHI_IDLE = 7'h01,
      APHI_START = 7'h02,
      APHI_CONVERT = 7'h04,
      APHI_READ_LOW = 7'h08,
      APHI_GAP = 7'h10,
      APHI_READ_HIGH = 7'h20,
      APHI_DONE = 7'h40
   } aphi_state_t;
endpackage : aphi_pkg

// ==== hw/aphi_pulse_gen.sv ====
// module: single pulse generator of programmable length
`timescale 1ns/1ps
module aphi_pulse_gen
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   aphi_pulse_if.timer pulse
);
   import aphi_pkg::*;
   logic [15:0] count_reg;
   logic [15:0] count_next;

   // ==========================================================
   // counter: reload on fire, run down to zero; a fire while busy restarts
   always_comb
   begin
      count_next = count_reg;
      if (pulse.fire)
      begin
         count_next = pulse.length;
      end
      else if (count_reg != 16'h0000)
      begin
         count_next = count_reg - 16'h0001;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         count_reg <= 16'h0000;
      end
      else
      begin
         count_reg <= count_next;
      end
   end

   assign pulse.active = (count_reg != 16'h0000);
endmodule : aphi_pulse_gen

// ==== hw/aphi_pulse_if.sv ====
// interface: counted pulse request and status between controller parts
`timescale 1ns/1ps
interface aphi_pulse_if;
   logic fire;
   logic [15:0] length;
   logic active;
   modport owner (output fire, output length, input active);
   modport timer (input fire, input length, output active);
endinterface : aphi_pulse_if

// ==== hw/aphi_sync3.sv ====
// module: three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module aphi_sync3
#(
   parameter logic RESET_VALUE = 1'b1
)
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic pin_in,
   output logic level_out
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic level_reg;
   logic level_next;

   // ==========================================================
   // stage 0 only feeds stage 1; level moves when stages 1 and 2 agree
   always_comb
   begin
      stage_next = {stage_reg[1:0], pin_in};
      level_next = level_reg;
      if (stage_reg[1] == stage_reg[2])
      begin
         level_next = stage_reg[2];
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         stage_reg <= {3{RESET_VALUE}};
         level_reg <= RESET_VALUE;
      end
      else
      begin
         stage_reg <= stage_next;
         level_reg <= level_next;
      end
   end

   assign level_out = level_reg;
endmodule : aphi_sync3

// ==== verification/aphi_adc_model.sv ====
// converter model: start edge, busy pin, tri-state data and external nibble latch
`timescale 1ns/1ps
module aphi_adc_model
#(
   parameter int CONV_T = 20
)
(
   input wire logic clk_sys_in,
   input wire logic conversion_start_n_in,
   input wire logic chip_select_n_in,
   input wire logic read_n_in,
   input wire logic [11:0] sample_in,
   output logic busy_n_out,
   output logic [11:0] data_out
);
   logic [11:0] held_reg;
   logic [11:0] last_reg;
   logic [3:0] latch_reg;
   logic armed;
   initial busy_n_out = 1'b1;
   initial armed = 1'b0;
   // ==========================================================
   // conversion: only a rise after a real low phase counts, so the
   // power-up rise from unknown gives no phantom busy
   always @(negedge conversion_start_n_in)
      armed = 1'b1;
   always @(posedge conversion_start_n_in)
   begin
      if (armed)
      begin
         held_reg = sample_in;
         busy_n_out = 1'b0;
         repeat (CONV_T) @(posedge clk_sys_in);
         #1 busy_n_out = 1'b1;
      end
   end
   // external latch grabs the upper bits on the first read
   always @(posedge clk_sys_in)
   begin
      if (!chip_select_n_in && !read_n_in)
         latch_reg <= held_reg[11:8];
      last_reg <= data_out;
   end
   // released lines show a changing pattern, never the last value
   always @*
   begin
      if (!chip_select_n_in && !read_n_in)
         data_out = held_reg;
      else if (!read_n_in)
         data_out = {latch_reg, ~last_reg[7:0]};
      else
         data_out = ~last_reg;
   end
endmodule : aphi_adc_model

// ==== verification/aphi_host_assertions.sv ====
// checker: pin timing of the converter host controller
`timescale 1ns/1ps
module aphi_host_assertions
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic start_req_in,
   input wire logic timer_enable_in,
   input wire logic use_delay_in,
   input wire logic byte_mode_in,
   input wire logic busy_out,
   input wire logic result_valid_out,
   input wire logic [11:0] result_out,
   input wire logic irq_n_out,
   input wire logic host_transfer_acknowledge_n_out,
   input wire logic conversion_start_n_out,
   input wire logic chip_select_n_out,
   input wire logic read_n_out,
   input wire logic converter_busy_n_in,
   input wire logic [11:0] data_in
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   // ==========================================================
   // strobe shapes and exclusions
   start_pulse_len_a: assert property ($fell(conversion_start_n_out) |->
      !conversion_start_n_out[*5] ##1 conversion_start_n_out) else $error("start pulse length");
   start_sets_busy_a: assert property ($rose(conversion_start_n_out) |-> busy_out)
      else $error("start edge outside conversion");
   no_read_busy_a: assert property (!read_n_out |-> converter_busy_n_in)
      else $error("read during conversion");
   start_not_read_a: assert property (!conversion_start_n_out |->
      chip_select_n_out && read_n_out) else $error("start overlaps read");
   select_with_read_a: assert property (!chip_select_n_out |-> !read_n_out)
      else $error("select without read strobe");
   read_wait_len_a: assert property ($fell(read_n_out) |->
      !read_n_out[*7] ##1 read_n_out) else $error("read strobe length");
   ack_follows_select_a: assert property ($fell(chip_select_n_out) |=>
      !host_transfer_acknowledge_n_out && !chip_select_n_out) else $error("no acknowledge");
   irq_single_pulse_a: assert property ($fell(irq_n_out) |->
      !irq_n_out[*4] ##1 irq_n_out) else $error("irq pulse length");
   irq_after_busy_a: assert property ($rose(converter_busy_n_in) && busy_out &&
      !use_delay_in |-> ##[1:6] !irq_n_out) else $error("irq missing");
   valid_one_cycle_a: assert property (result_valid_out |=> !result_valid_out)
      else $error("valid too long");
   cover property ($fell(read_n_out) && chip_select_n_out);
   cover property ($fell(irq_n_out));
   cover property (result_valid_out && byte_mode_in);
endmodule : aphi_host_assertions
bind aphi_host aphi_host_assertions aphi_host_assertions_inst (.*);

// ==== verification/testbench.sv ====
// testbench: converter host controller against the converter model
`timescale 1ns/1ps
module testbench;
   import aphi_pkg::*;
   logic clk_sys_in, reset_in, start_req_in, timer_enable_in, use_delay_in, byte_mode_in;
   logic busy_out, result_valid_out, irq_n_out, host_transfer_acknowledge_n_out;
   logic conversion_start_n_out, chip_select_n_out, read_n_out, converter_busy_n_in;
   logic [RESULT_WIDTH-1:0] result_out, data_in, sample;
   logic [RESULT_WIDTH-1:0] exp_q[$];
   int fail_count, tests_run;
   localparam int RD_LEN = READ_STROBE_CYCLES + WAIT_STATE_CYCLES;
   aphi_host #(.TIMER_PERIOD(20), .CONV_WAIT(30)) aphi_host_inst (.*);
   aphi_adc_model #(.CONV_T(20)) aphi_adc_model_inst (.clk_sys_in(clk_sys_in),
      .conversion_start_n_in(conversion_start_n_out), .chip_select_n_in(chip_select_n_out),
      .read_n_in(read_n_out), .sample_in(sample), .busy_n_out(converter_busy_n_in),
      .data_out(data_in));
   // ==========================================================
   // clock, compare, verdict
   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // monitor: each valid pulse takes the oldest expected result
   always @(negedge clk_sys_in)
   begin
      if (result_valid_out === 1'b1 && exp_q.size() == 0)
         check("extra result", 12'h001, 12'h000);
      else if (result_valid_out === 1'b1)
         check("result_out", result_out, exp_q.pop_front());
   end
   // hang guard: about fifteen times the roughly seven hundred cycles the runs need
   initial
   begin
      #100000;
      fail_count++;
      end_sim();
   end
   // ==========================================================
   // one conversion; a second request mid-conversion must be refused
   task automatic run(input logic [11:0] s, input logic bm, input logic ud, input logic tm);
      int n;
      int ack_low;
      int irq_low;
      int rd_low;
      n = 0;
      ack_low = 0;
      irq_low = 0;
      rd_low = 0;
      sample = s;
      byte_mode_in = bm;
      use_delay_in = ud;
      exp_q.push_back(s);
      timer_enable_in = tm;
      start_req_in = !tm;
      @(negedge clk_sys_in);
      start_req_in = 1'b0;
      while (busy_out !== 1'b1 && n < 100)
      begin
         @(negedge clk_sys_in);
         n++;
      end
      timer_enable_in = 1'b0;
      check("busy_out", {11'h000, busy_out}, 12'h001);
      repeat (10) @(negedge clk_sys_in);
      start_req_in = 1'b1;
      @(negedge clk_sys_in);
      start_req_in = 1'b0;
      while (busy_out !== 1'b0 && n < 600)
      begin
         @(negedge clk_sys_in);
         n++;
         ack_low += (host_transfer_acknowledge_n_out === 1'b0);
         irq_low += (irq_n_out === 1'b0);
         rd_low += (read_n_out === 1'b0);
      end
      // acknowledge trails select by one cycle; strobe is counted length plus wait
      check("ack cycles", 12'(ack_low), 12'(RD_LEN - 1));
      check("irq cycles", 12'(irq_low), 12'(IRQ_PULSE_CYCLES));
      check("read cycles", 12'(rd_low), 12'(bm ? 2 * RD_LEN : RD_LEN));
      repeat (3) @(negedge clk_sys_in);
      check("result held", result_out, s);
      check("pending results", 12'(exp_q.size()), 12'h000);
   endtask : run
   initial
   begin
      void'($urandom(32'h0EF3));
      reset_in = 1'b1;
      start_req_in = 1'b0;
      timer_enable_in = 1'b0;
      use_delay_in = 1'b0;
      byte_mode_in = 1'b0;
      sample = 12'h000;
      fail_count = 0;
      tests_run = 0;
      repeat (4) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      reset_in = 1'b0;
      check("idle start", {11'h000, conversion_start_n_out}, 12'h001);
      check("idle select", {11'h000, chip_select_n_out}, 12'h001);
      check("idle read", {11'h000, read_n_out}, 12'h001);
      check("idle ack", {11'h000, host_transfer_acknowledge_n_out}, 12'h001);
      check("idle irq", {11'h000, irq_n_out}, 12'h001);
      check("idle busy valid", {10'h000, busy_out, result_valid_out}, 12'h000);
      // all mode mixes, boundary codes first, then random codes
      for (int m = 0; m < 12; m++)
      begin
         run(m == 0 ? 12'h000 : m == 1 ? 12'hFFF : 12'($urandom), m[0], m[1], m[2]);
      end
      end_sim();
   end
endmodule : testbench
